// ===== ivm_consts.svh
// constants for the interrupt vector mapper
`ifndef IVM_CONSTS_SVH
`define IVM_CONSTS_SVH

// ----------------------------------------------------------------
// vector numbering
// ----------------------------------------------------------------
`define IVM_VEC_STACK_PTR     8'h00
`define IVM_VEC_RESET_PC      8'h01
`define IVM_VEC_NMI           8'h02
`define IVM_VEC_HARD_FAULT    8'h03
`define IVM_VEC_MEM_FAULT     8'h04
`define IVM_VEC_BUS_FAULT     8'h05
`define IVM_VEC_USAGE_FAULT   8'h06
`define IVM_VEC_SUPERVISOR    8'h0B
`define IVM_VEC_DEBUG_MON     8'h0C
`define IVM_VEC_PEND_SERVICE  8'h0E
`define IVM_VEC_SYS_TICK      8'h0F
`define IVM_IRQ_VEC_BASE      8'h10
`define IVM_LAST_VECTOR       8'h61

// ----------------------------------------------------------------
// table layout and word selection
// ----------------------------------------------------------------
`define IVM_TABLE_BASE        32'h0000_0000
`define IVM_ENTRY_SHIFT       2
`define IVM_WORD_SHIFT        5
`define IVM_PRIO_SHIFT        2

// ----------------------------------------------------------------
// request lines
// ----------------------------------------------------------------
`define IVM_NUM_IRQ           82
`define IVM_DMA_PAIRS         16
`define IVM_SW_IRQ            64

`endif

// ===== ivm_pkg.sv
// types shared by the interrupt vector mapper
package ivm_pkg;

  typedef enum logic [1:0] {
    VEC_CORE     = 2'b00,
    VEC_PERIPH   = 2'b01,
    VEC_RESERVED = 2'b11,
    VEC_UNMAPPED = 2'b10
  } vec_kind_t;

  typedef struct packed {
    logic        hit;
    vec_kind_t   kind;
    logic [7:0]  vector;
    logic [6:0]  irq;
    logic [31:0] entry_addr;
    logic [1:0]  ctrl_word;
    logic [4:0]  prio_word;
    logic [1:0]  prio_field;
  } vec_info_t;

endpackage

// ===== vector_decode.sv
// combinational decode of one vector number into its table facts
`timescale 1ns/1ps
module vector_decode
  import ivm_pkg::*;
(
  input  wire logic [7:0] vector,
  output vec_info_t       info
);
`include "ivm_consts.svh"

  logic [7:0] irq_full;

  always_comb begin
    irq_full        = vector - `IVM_IRQ_VEC_BASE;
    info            = '0;
    info.vector     = vector;
    info.entry_addr = `IVM_TABLE_BASE + ({24'h00_0000, vector} << `IVM_ENTRY_SHIFT);
    if (vector > `IVM_LAST_VECTOR) begin
      info.kind = VEC_UNMAPPED;
    end else if (vector < `IVM_IRQ_VEC_BASE) begin
      unique case (vector)
        `IVM_VEC_STACK_PTR, `IVM_VEC_RESET_PC, `IVM_VEC_NMI,
        `IVM_VEC_HARD_FAULT, `IVM_VEC_MEM_FAULT, `IVM_VEC_BUS_FAULT,
        `IVM_VEC_USAGE_FAULT, `IVM_VEC_SUPERVISOR, `IVM_VEC_DEBUG_MON,
        `IVM_VEC_PEND_SERVICE, `IVM_VEC_SYS_TICK: begin
          info.kind = VEC_CORE;
          info.hit  = 1'b1;
        end
        default: info.kind = VEC_RESERVED;
      endcase
    end else begin
      info.kind       = VEC_PERIPH;
      info.hit        = 1'b1;
      info.irq        = irq_full[6:0];
      // control word is irq div 32
      info.ctrl_word  = irq_full[6:`IVM_WORD_SHIFT];
      // priority word is irq div 4
      info.prio_word  = irq_full[6:`IVM_PRIO_SHIFT];
      info.prio_field = irq_full[1:0];
    end
  end

endmodule // vector_decode

// ===== interrupt_vector_mapper.sv
// interrupt vector mapper: request line merge and vector lookup
`timescale 1ns/1ps
`include "ivm_consts.svh"
module interrupt_vector_mapper
  import ivm_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    resetn,
  input  wire logic [31:0]             dma_done,
  input  wire logic [`IVM_NUM_IRQ-1:0] periph_req,
  input  wire logic                    sw_pend_set,
  input  wire logic                    sw_pend_clear,
  input  wire logic                    vec_query,
  input  wire logic [7:0]              vec_query_num,
  input  wire logic                    irq_query,
  input  wire logic [6:0]              irq_query_num,
  output logic [`IVM_NUM_IRQ-1:0]      irq_line,
  output logic                         sw_pending,
  output logic                         vec_valid,
  output vec_info_t                    vec_answer,
  output logic                         irq_valid,
  output vec_info_t                    irq_answer
);

  // ----------------------------------------------------------------
  // dma channel pairing
  // ----------------------------------------------------------------
  logic [`IVM_DMA_PAIRS-1:0] dma_low;
  logic [`IVM_DMA_PAIRS-1:0] dma_high;
  logic [`IVM_DMA_PAIRS-1:0] dma_pair;

  // upper sixteen channels fold onto the lower sixteen
  always_comb begin
    dma_low  = dma_done[`IVM_DMA_PAIRS-1:0];
    dma_high = dma_done[2*`IVM_DMA_PAIRS-1:`IVM_DMA_PAIRS];
  end

  // channel n with n plus 16
  // same pairing for irq 1
  // plain or, both channels may finish in one cycle
  for (genvar p = 0; p < `IVM_DMA_PAIRS; p++) begin : g_pair
    assign dma_pair[p] = dma_low[p] | dma_high[p];
  end

  // ----------------------------------------------------------------
  // software pend flag
  // ----------------------------------------------------------------
  logic sw_pend_d;
  logic sw_pend_q;

  always_comb begin
    // set wins so a pend write is never lost
    sw_pend_d = sw_pend_set | (sw_pend_q & ~sw_pend_clear);
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sw_pend_q <= 1'b0;
    end else begin
      sw_pend_q <= sw_pend_d;
    end
  end

  assign sw_pending = sw_pend_q;

  // ----------------------------------------------------------------
  // request line merge
  // ----------------------------------------------------------------
  logic [`IVM_NUM_IRQ-1:0] dma_map;
  logic [`IVM_NUM_IRQ-1:0] irq_line_d;
  logic [`IVM_NUM_IRQ-1:0] irq_line_q;

  always_comb begin
    dma_map                     = '0;
    dma_map[`IVM_DMA_PAIRS-1:0] = dma_pair;
    irq_line_d                  = dma_map | periph_req;
    irq_line_d[`IVM_SW_IRQ]     = sw_pend_q;
  end

  // registered so the core never sees a half-merged level
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      irq_line_q <= '0;
    end else begin
      irq_line_q <= irq_line_d;
    end
  end

  assign irq_line = irq_line_q;

  // ----------------------------------------------------------------
  // irq to vector conversion
  // ----------------------------------------------------------------
  logic [7:0] irq_as_vec;

  // irq named sixteen below vector
  // eight bits hold irq 127 plus 16, so no carry is lost
  always_comb begin
    irq_as_vec = {1'b0, irq_query_num} + `IVM_IRQ_VEC_BASE;
  end

  // ----------------------------------------------------------------
  // table decode
  // ----------------------------------------------------------------
  vec_info_t vec_info;
  vec_info_t irq_info;

  // one decoder a port, so both ports may query in one cycle
  vector_decode u_vec_decode (
    .vector (vec_query_num),
    .info   (vec_info)
  );

  vector_decode u_irq_decode (
    .vector (irq_as_vec),
    .info   (irq_info)
  );

  // ----------------------------------------------------------------
  // vector port strobe
  // ----------------------------------------------------------------
  logic vec_valid_d;
  logic vec_valid_q;

  always_comb begin
    vec_valid_d = vec_query;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      vec_valid_q <= 1'b0;
    end else begin
      vec_valid_q <= vec_valid_d;
    end
  end

  assign vec_valid = vec_valid_q;

  // ----------------------------------------------------------------
  // vector port answer
  // ----------------------------------------------------------------
  vec_info_t vec_ans_d;
  vec_info_t vec_ans_q;

  // answer holds until the next query, so the core may sample late
  always_comb begin
    vec_ans_d = vec_ans_q;
    if (vec_query) begin
      vec_ans_d = vec_info;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      vec_ans_q <= '0;
    end else begin
      vec_ans_q <= vec_ans_d;
    end
  end

  assign vec_answer = vec_ans_q;

  // ----------------------------------------------------------------
  // irq port strobe
  // ----------------------------------------------------------------
  logic irq_valid_d;
  logic irq_valid_q;

  always_comb begin
    irq_valid_d = irq_query;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      irq_valid_q <= 1'b0;
    end else begin
      irq_valid_q <= irq_valid_d;
    end
  end

  assign irq_valid = irq_valid_q;

  // ----------------------------------------------------------------
  // irq port answer
  // ----------------------------------------------------------------
  vec_info_t irq_ans_d;
  vec_info_t irq_ans_q;

  // held like the vector port answer
  always_comb begin
    irq_ans_d = irq_ans_q;
    if (irq_query) begin
      irq_ans_d = irq_info;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      irq_ans_q <= '0;
    end else begin
      irq_ans_q <= irq_ans_d;
    end
  end

  assign irq_answer = irq_ans_q;

endmodule // interrupt_vector_mapper

// ===== ivm_sva.sv
// checker for the interrupt vector mapper
`timescale 1ns/1ps
`include "ivm_consts.svh"
module ivm_sva
  import ivm_pkg::*;
(
  input wire logic                    ref_clk,
  input wire logic                    resetn,
  input wire logic [31:0]             dma_done,
  input wire logic [`IVM_NUM_IRQ-1:0] periph_req,
  input wire logic                    sw_pend_set,
  input wire logic                    vec_query,
  input wire logic [7:0]              vec_query_num,
  input wire logic [`IVM_NUM_IRQ-1:0] irq_line,
  input wire logic                    sw_pending,
  input wire logic                    vec_valid,
  input wire vec_info_t               vec_answer,
  input wire logic                    irq_valid,
  input wire vec_info_t               irq_answer
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_irq0_pair: assert property ($past(resetn) |-> irq_line[0] ==
    $past(dma_done[0] | dma_done[16] | periph_req[0])) else $error("irq 0 merge");
  a_irq1_pair: assert property ($past(resetn) |-> irq_line[1] ==
    $past(dma_done[1] | dma_done[17] | periph_req[1])) else $error("irq 1 merge");
  a_sw_line: assert property ($past(resetn) |-> irq_line[64] == $past(sw_pending))
    else $error("sw line");
  a_sw_set: assert property (sw_pend_set |=> sw_pending) else $error("sw set");
  a_vec_answer: assert property (vec_query |=> vec_valid &&
    vec_answer.vector == $past(vec_query_num)) else $error("vec answer");
  a_entry_addr: assert property (vec_valid |->
    vec_answer.entry_addr == {22'h0, vec_answer.vector, 2'b00}) else $error("entry");
  a_irq_offset: assert property (irq_valid && irq_answer.hit |->
    irq_answer.vector == {1'b0, irq_answer.irq} + 8'h10) else $error("irq offset");
  a_word_index: assert property (irq_valid && irq_answer.hit |->
    {irq_answer.ctrl_word, irq_answer.prio_word} == {irq_answer.irq[6:5],
    irq_answer.irq[6:2]}) else $error("word index");
  c_reserved: cover property (vec_valid && vec_answer.kind == VEC_RESERVED);
  c_pair: cover property (irq_line[1]);
  c_sw: cover property (sw_pending);
endmodule // ivm_sva

// ===== req_source.sv
// dma completion source on the far side
`timescale 1ns/1ps
module req_source (
  input  wire logic       ref_clk,
  input  wire logic       fire,
  input  wire logic [4:0] chan,
  output logic [31:0]     dma_done = 32'h0
);
  // done level held while fired, idle low otherwise
  always @(posedge ref_clk) dma_done <= fire ? 32'h1 << chan : 32'h0;
endmodule // req_source

// ===== interrupt_vector_mapper_test.sv
// self-checking bench for the interrupt vector mapper
`timescale 1ns/1ps
`include "ivm_consts.svh"
module interrupt_vector_mapper_test;
  import ivm_pkg::*;
  logic ref_clk = 0, resetn = 0, fire = 0, sw_pend_set = 0, sw_pend_clear = 0;
  logic vec_query = 0, irq_query = 0, sw_pending, vec_valid, irq_valid;
  logic [4:0] chan = 0;
  logic [7:0] vec_query_num = 0, v;
  logic [6:0] irq_query_num = 0;
  logic [31:0] dma_done;
  logic [81:0] periph_req = 0, irq_line;
  vec_info_t vec_answer, irq_answer;
  int n_fail = 0, checks_done = 0;
  always #50 ref_clk = ~ref_clk;
  req_source i_req_source(.ref_clk, .fire, .chan, .dma_done);
  interrupt_vector_mapper i_interrupt_vector_mapper(.ref_clk, .resetn, .dma_done,
    .periph_req, .sw_pend_set, .sw_pend_clear, .vec_query, .vec_query_num, .irq_query,
    .irq_query_num, .irq_line, .sw_pending, .vec_valid, .vec_answer, .irq_valid, .irq_answer);
  task tick;
    @(posedge ref_clk) #1;
  endtask
  task chk(string what, logic [81:0] seen, logic [81:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task summarize;
    if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // back-to-back lookups, boundaries 15/16 and 97/98
  task t_vec;
    vec_query = 1;
    for (int i = 0; i < 21; i++) begin
      v = 8'((i < 19) ? i : i + 78);
      vec_query_num = v;
      tick;
      chk("kind", vec_answer.kind, v > 97 ? 2'b10 : v > 15 ? 2'b01 :
        (v inside {7, 8, 9, 10, 13}) ? 2'b11 : 2'b00);
      chk("addr", vec_answer.entry_addr, {v, 2'b00});
      chk("vec_valid", vec_valid, 1);
      chk("vhit", vec_answer.hit, v < 98 && !(v inside {7, 8, 9, 10, 13}));
      chk("virq", vec_answer.irq, (v > 15 && v < 98) ? v - 16 : 0);
    end
    vec_query = 0;
    tick;
    chk("vec_valid", vec_valid, 0);
    chk("vec hold", vec_answer.vector, 98);
  endtask
  task t_irq;
    logic [6:0] q[6] = '{0, 31, 32, 63, 81, 127};
    irq_query = 1;
    foreach (q[i]) begin
      irq_query_num = q[i];
      tick;
      chk("hit", irq_answer.hit, q[i] < 82);
      if (q[i] < 82) chk("vec", irq_answer.vector, q[i] + 16);
      if (q[i] < 82) chk("ctrl", irq_answer.ctrl_word, q[i] / 32);
      if (q[i] < 82) chk("prio", irq_answer.prio_word, q[i] / 4);
      if (q[i] < 82) chk("field", irq_answer.prio_field, q[i] % 4);
      if (q[i] < 82) chk("irq", irq_answer.irq, q[i]);
      chk("irq_valid", irq_valid, 1);
    end
    irq_query = 0;
    tick;
    chk("irq_valid", irq_valid, 0);
    chk("irq hold", irq_answer.vector, 143);
  endtask
  // every channel of the first two shared pairs, then a plain line
  task t_merge;
    logic [4:0] c[4] = '{0, 16, 1, 17};
    foreach (c[i]) begin
      chan = c[i];
      fire = 1;
      tick;
      tick;
      chk("pair", irq_line, 82'h1 << c[i][3:0]);
      fire = 0;
      tick;
    end
    periph_req = 82'h1 << 20 | 82'h1 << 64;
    tick;
    tick;
    chk("line", irq_line, 82'h1 << 20);
    periph_req = 0;
  endtask
  task t_sw;
    sw_pend_set = 1;
    tick;
    sw_pend_clear = 1;
    chk("set", sw_pending, 1);
    tick;
    sw_pend_set = 0;
    chk("line64", irq_line[64], 1);
    chk("set wins", sw_pending, 1);
    tick;
    sw_pend_clear = 0;
    chk("clear", sw_pending, 0);
    tick;
    chk("line64 off", irq_line[64], 0);
  endtask
  // mid-run reset drops the pend flag and the held answer
  task t_reset;
    sw_pend_set = 1;
    tick;
    sw_pend_set = 0;
    resetn = 0;
    tick;
    resetn = 1;
    chk("rst pend", sw_pending, 0);
    chk("rst answer", vec_answer, 0);
    tick;
    chk("rst line", irq_line, 0);
  endtask
  initial begin
    repeat (3) tick;
    resetn = 1;
    chk("reset", irq_line, 0);
    tick;
    t_vec;
    t_irq;
    t_merge;
    t_sw;
    t_reset;
    summarize;
  end
  initial begin
    repeat (400) @(posedge ref_clk);
    n_fail++;
    summarize;
  end
endmodule // interrupt_vector_mapper_test
bind interrupt_vector_mapper ivm_sva i_ivm_sva(.ref_clk, .resetn, .dma_done, .periph_req,
  .sw_pend_set, .vec_query, .vec_query_num, .irq_line, .sw_pending, .vec_valid,
  .vec_answer, .irq_valid, .irq_answer);
